// *** common/hsq_pkg.sv ***
package hsq_pkg;

   // ----------------------------------------
   // Limits, codes and timing
   // ----------------------------------------
   localparam logic [12:0] SPEED_MAX   = 13'h1770;
   localparam logic [11:0] ACCEL_MAX   = 12'hBB8;
   localparam logic [3:0]  TYPE_LIM_IDX = 4'h3;
   localparam logic [3:0]  TYPE_LIM_EDGE = 4'h4;
   localparam logic [3:0]  TYPE_IDX    = 4'h5;
   localparam logic [7:0]  ERR_HOMING  = 8'h44;
   localparam logic [7:0]  ERR_NONE    = 8'h00;
   localparam logic [7:0]  CNT_RESET   = 8'h00;
   localparam int          CLK_HZ      = 20000000;
   localparam int          LIM_LAT_MS  = 2;
   // Longest time, so rounded down
   localparam int          LIM_LAT_CYC = LIM_LAT_MS * (CLK_HZ / 1000);

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [12:0]        fast_speed;
      logic [12:0]        slow_speed;
      logic [12:0]        offset_speed;
      logic [11:0]        accel;
      logic [11:0]        decel;
      logic               direction;
      logic [3:0]         homing_type;
      logic               offset_en;
      logic [7:0]         index_count;
      logic signed [31:0] home_offset;
      logic [1:0]         ot_action;
   } hsq_cfg_t;

   typedef struct packed {
      logic        run;
      logic        dir_neg;
      logic [12:0] speed;
      logic [11:0] accel;
      logic [11:0] decel;
   } hsq_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_FAST, ST_FAST_STOP, ST_LEAVE,
      ST_COUNT, ST_HOME_STOP, ST_OFFSET, ST_ERR
   } hsq_state_t;

endpackage : hsq_pkg

// *** design/hsq_top.sv ***
module hsq_top #(
   parameter int LIM_LAT_CYC = hsq_pkg::LIM_LAT_CYC
) (
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              start,
   input  wire hsq_pkg::hsq_cfg_t cfg,
   input  wire logic              limit_pos,
   input  wire logic              limit_neg,
   input  wire logic              index_pulse,
   input  wire logic              motor_stopped,
   input  wire logic              offset_done,
   output logic                   cmd_run,
   output logic                   cmd_dir_neg,
   output logic [12:0]            cmd_speed,
   output logic [11:0]            cmd_accel,
   output logic [11:0]            cmd_decel,
   output logic                   home_set,
   output logic                   offset_go,
   output logic [31:0]            offset_dist,
   output logic [12:0]            offset_speed,
   output logic                   homing_done,
   output logic                   homing_err,
   output logic [7:0]             err_code
);

   // ----------------------------------------
   // State record
   // ----------------------------------------
   typedef struct packed {
      hsq_pkg::hsq_state_t st;
      hsq_pkg::hsq_cmd_t   cmd;
      logic [7:0]          cnt;
      logic                idx_q;
      logic                home;
      logic                off_go;
      logic [31:0]         off_dist;
      logic [12:0]         off_spd;
      logic                done;
      logic                err;
      logic [7:0]          code;
   } hsq_regs_t;

   hsq_regs_t s_r;
   hsq_regs_t s_nxt;

   // Settings above range are clamped
   function automatic logic [12:0] hsq_spd(input logic [12:0] v);
      return (v > hsq_pkg::SPEED_MAX) ? hsq_pkg::SPEED_MAX : v;
   endfunction : hsq_spd

   function automatic logic [11:0] hsq_acc(input logic [11:0] v);
      return (v > hsq_pkg::ACCEL_MAX) ? hsq_pkg::ACCEL_MAX : v;
   endfunction : hsq_acc

   logic [12:0] fast_c;
   logic [12:0] slow_c;
   logic [11:0] acc_c;
   logic [11:0] dec_c;
   logic        lim_home;
   logic        lim_opp;
   logic        idx_rise;
   logic        bad_cfg;
   logic        type_ok;
   logic [7:0]  cnt_inc;

   // ----------------------------------------
   // Decoded inputs
   // ----------------------------------------
   // Limit sensors named by homing direction
   always_comb begin
      fast_c   = hsq_spd(cfg.fast_speed);
      slow_c   = hsq_spd(cfg.slow_speed);
      acc_c    = hsq_acc(cfg.accel);
      dec_c    = hsq_acc(cfg.decel);
      lim_home = cfg.direction ? limit_neg : limit_pos;
      lim_opp  = cfg.direction ? limit_pos : limit_neg;
      idx_rise = index_pulse & ~s_r.idx_q;
      cnt_inc  = 8'(s_r.cnt + 8'h01);
      type_ok  = (cfg.homing_type == hsq_pkg::TYPE_LIM_IDX)
              || (cfg.homing_type == hsq_pkg::TYPE_LIM_EDGE)
              || (cfg.homing_type == hsq_pkg::TYPE_IDX);
      // Fast speed unused by index-only homing
      bad_cfg  = !type_ok || (slow_c == 13'h0000)
              || (acc_c == 12'h000) || (dec_c == 12'h000)
              || ((cfg.homing_type != hsq_pkg::TYPE_IDX)
                  && (fast_c == 13'h0000));
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      s_nxt        = s_r;
      s_nxt.idx_q  = index_pulse;
      s_nxt.home   = 1'b0;
      s_nxt.off_go = 1'b0;
      unique case (s_r.st)
         hsq_pkg::ST_IDLE: begin
            if (start) begin
               s_nxt.done      = 1'b0;
               s_nxt.cnt       = hsq_pkg::CNT_RESET;
               s_nxt.cmd.accel = acc_c;
               s_nxt.cmd.decel = dec_c;
               if (bad_cfg) begin
                  s_nxt.st   = hsq_pkg::ST_ERR;
                  s_nxt.err  = 1'b1;
                  s_nxt.code = hsq_pkg::ERR_HOMING;
               end else if (cfg.homing_type == hsq_pkg::TYPE_IDX) begin
                  s_nxt.cmd.run     = 1'b1;
                  s_nxt.cmd.dir_neg = cfg.direction;
                  s_nxt.cmd.speed   = slow_c;
                  s_nxt.st          = hsq_pkg::ST_COUNT;
               end else begin
                  s_nxt.cmd.run   = 1'b1;
                  s_nxt.cmd.speed = fast_c;
                  // Type 3 runs away from home first
                  s_nxt.cmd.dir_neg = (cfg.homing_type == hsq_pkg::TYPE_LIM_IDX)
                                    ? ~cfg.direction : cfg.direction;
                  s_nxt.st = hsq_pkg::ST_FAST;
               end
            end
         end
         hsq_pkg::ST_FAST: begin
            if ((cfg.homing_type == hsq_pkg::TYPE_LIM_IDX) ? lim_opp : lim_home) begin
               s_nxt.cmd.run   = 1'b0;
               s_nxt.cmd.decel = cfg.ot_action[0] ? 12'h000 : dec_c;
               s_nxt.st        = hsq_pkg::ST_FAST_STOP;
            end
         end
         hsq_pkg::ST_FAST_STOP: begin
            // Sensor assumed steady while braking
            if (motor_stopped) begin
               s_nxt.cmd.run   = 1'b1;
               s_nxt.cmd.speed = slow_c;
               s_nxt.cmd.decel = dec_c;
               s_nxt.cmd.dir_neg = (cfg.homing_type == hsq_pkg::TYPE_LIM_IDX)
                                 ? cfg.direction : ~cfg.direction;
               s_nxt.st = hsq_pkg::ST_LEAVE;
            end
         end
         hsq_pkg::ST_LEAVE: begin
            if (cfg.homing_type == hsq_pkg::TYPE_LIM_IDX) begin
               if (!lim_opp) begin
                  s_nxt.st = hsq_pkg::ST_COUNT;
               end
            end else if (lim_opp) begin
               s_nxt.st      = hsq_pkg::ST_ERR;
               s_nxt.err     = 1'b1;
               s_nxt.code    = hsq_pkg::ERR_HOMING;
               s_nxt.cmd.run = 1'b0;
               s_nxt.cmd.decel = cfg.ot_action[0] ? 12'h000 : dec_c;
            end else if (!lim_home) begin
               // Release seen in the cycle it arrives, home set at the next edge
               s_nxt.home    = 1'b1;
               s_nxt.cmd.run = 1'b0;
               s_nxt.st      = hsq_pkg::ST_HOME_STOP;
            end
         end
         hsq_pkg::ST_COUNT: begin
            if (lim_home) begin
               s_nxt.st      = hsq_pkg::ST_ERR;
               s_nxt.err     = 1'b1;
               s_nxt.code    = hsq_pkg::ERR_HOMING;
               s_nxt.cmd.run = 1'b0;
               s_nxt.cmd.decel = cfg.ot_action[0] ? 12'h000 : dec_c;
            end else if (idx_rise) begin
               s_nxt.cnt = cnt_inc;
               // A count of zero acts as one
               if (cnt_inc >= cfg.index_count) begin
                  s_nxt.home    = 1'b1;
                  s_nxt.cmd.run = 1'b0;
                  s_nxt.st      = hsq_pkg::ST_HOME_STOP;
               end
            end
         end
         hsq_pkg::ST_HOME_STOP: begin
            if (motor_stopped) begin
               if (cfg.offset_en && (cfg.home_offset != 32'sh0)) begin
                  s_nxt.off_go   = 1'b1;
                  s_nxt.off_dist = cfg.home_offset;
                  s_nxt.off_spd  = hsq_spd(cfg.offset_speed);
                  s_nxt.st       = hsq_pkg::ST_OFFSET;
               end else begin
                  s_nxt.done = 1'b1;
                  s_nxt.st   = hsq_pkg::ST_IDLE;
               end
            end
         end
         hsq_pkg::ST_OFFSET: begin
            if (offset_done) begin
               s_nxt.done = 1'b1;
               s_nxt.st   = hsq_pkg::ST_IDLE;
            end
         end
         hsq_pkg::ST_ERR: begin
            // Alarm is held until reset
            s_nxt.cmd.run = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign cmd_run      = s_r.cmd.run;
   assign cmd_dir_neg  = s_r.cmd.dir_neg;
   assign cmd_speed    = s_r.cmd.speed;
   assign cmd_accel    = s_r.cmd.accel;
   assign cmd_decel    = s_r.cmd.decel;
   assign home_set     = s_r.home;
   assign offset_go    = s_r.off_go;
   assign offset_dist  = s_r.off_dist;
   assign offset_speed = s_r.off_spd;
   assign homing_done  = s_r.done;
   assign homing_err   = s_r.err;
   assign err_code     = s_r.code;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Cycles from limit release to home, kept for the bound
   logic [31:0] lat_r;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lat_r <= 32'h0000_0000;
      end else if (s_r.st == hsq_pkg::ST_LEAVE && !lim_home
                   && cfg.homing_type == hsq_pkg::TYPE_LIM_EDGE) begin
         lat_r <= 32'(lat_r + 32'h1);
      end else begin
         lat_r <= 32'h0000_0000;
      end
   end

   sequence count_last_s;
      s_r.st == hsq_pkg::ST_COUNT && !lim_home && idx_rise
         && cnt_inc >= cfg.index_count;
   endsequence

   sequence home_stop_s;
      home_set && !cmd_run && s_r.st == hsq_pkg::ST_HOME_STOP;
   endsequence

   sequence trip_s;
      s_r.st == hsq_pkg::ST_ERR && homing_err && err_code == hsq_pkg::ERR_HOMING;
   endsequence

   fast_away_a: assert property (@(posedge mclk) disable iff (!rst_b)
      s_r.st == hsq_pkg::ST_FAST && cfg.homing_type == hsq_pkg::TYPE_LIM_IDX
      |-> cmd_dir_neg == !cfg.direction && cmd_speed == fast_c)
      else $error("fast leg not away from home");

   count_home_a: assert property (@(posedge mclk) disable iff (!rst_b)
      count_last_s |=> home_stop_s)
      else $error("home not declared at chosen index pulse");

   zero_trip_a: assert property (@(posedge mclk) disable iff (!rst_b)
      s_r.st == hsq_pkg::ST_IDLE && start && slow_c == 13'h0000 |=> trip_s)
      else $error("zero setting did not trip");

   travel_trip_a: assert property (@(posedge mclk) disable iff (!rst_b)
      s_r.st == hsq_pkg::ST_COUNT && lim_home |=> trip_s ##1 trip_s)
      else $error("travel limit while counting did not trip");

   opp_trip_a: assert property (@(posedge mclk) disable iff (!rst_b)
      s_r.st == hsq_pkg::ST_LEAVE && lim_opp
      && cfg.homing_type == hsq_pkg::TYPE_LIM_EDGE |=> trip_s)
      else $error("opposite limit after reversal did not trip");

   ot_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
      s_r.st == hsq_pkg::ST_FAST && lim_home && cfg.ot_action[0]
      && cfg.homing_type == hsq_pkg::TYPE_LIM_EDGE
      |=> !cmd_run && cmd_decel == 12'h000)
      else $error("instant stop not commanded");

   edge_lat_a: assert property (@(posedge mclk) disable iff (!rst_b)
      lat_r < 32'(LIM_LAT_CYC) && lat_r < 32'h2)
      else $error("limit release took too long to become home");

   slow_dir_a: assert property (@(posedge mclk) disable iff (!rst_b)
      s_r.st == hsq_pkg::ST_COUNT && cmd_run |-> cmd_dir_neg == cfg.direction)
      else $error("count leg in wrong direction");

   skip_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
      s_r.st == hsq_pkg::ST_HOME_STOP && motor_stopped && !cfg.offset_en
      |=> homing_done && !offset_go)
      else $error("offset not skipped");

   err_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      homing_err |=> homing_err [*2])
      else $error("error indication dropped");

endmodule : hsq_top

// *** verification/hsq_motor_model.sv ***
// ----------------------------------------
// Motor, encoder and sensor stand-in
// ----------------------------------------
module hsq_motor_model #(
   parameter int LIM     = 210,
   parameter int IDX_GAP = 50
) (
   input  wire logic               mclk,
   input  wire logic               load,
   input  wire logic signed [31:0] load_pos,
   input  wire logic               stuck_pos,
   input  wire logic               cmd_run,
   input  wire logic               cmd_dir_neg,
   input  wire logic [11:0]        cmd_decel,
   input  wire logic               offset_go,
   output logic                    limit_pos,
   output logic                    limit_neg,
   output logic                    index_pulse,
   output logic                    motor_stopped,
   output logic                    offset_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int   pos   = 0;
   int   coast = 0;
   int   odly  = 0;
   logic dir_q = 1'b0;
   logic run_q = 1'b0;

   // One count of travel a cycle; a ramped stop coasts four counts past the command
   always @(posedge mclk) begin
      run_q <= cmd_run;
      odly  <= offset_go ? 3 : ((odly > 0) ? odly - 1 : 0);
      if (load) begin
         pos   <= load_pos;
         coast <= 0;
      end else if (cmd_run) begin
         dir_q <= cmd_dir_neg;
         pos   <= cmd_dir_neg ? pos - 1 : pos + 1;
      end else if (run_q) begin
         coast <= (cmd_decel == 12'h000) ? 0 : 4;
      end else if (coast > 0) begin
         coast <= coast - 1;
         pos   <= dir_q ? pos - 1 : pos + 1;
      end
   end

   // Sensors follow position, except that stuck_pos holds limit_pos active; the active zone outlasts any coast distance
   assign limit_pos     = stuck_pos || (pos >= LIM);
   assign limit_neg     = pos <= -LIM;
   assign index_pulse   = (pos % IDX_GAP) == 0;
   assign motor_stopped = !cmd_run && !run_q && (coast == 0);
   assign offset_done   = odly == 1;
endmodule : hsq_motor_model

// *** verification/test_homing_sequencer_limit_zphase.sv ***
module test_homing_sequencer_limit_zphase;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Stimulus, wiring and observation state
   // ----------------------------------------
   logic               mclk  = 1'b0;
   logic               rst_b = 1'b0;
   logic               start = 1'b0;
   hsq_pkg::hsq_cfg_t  cfg   = '0;
   logic               load  = 1'b0;
   logic               stuck = 1'b0;
   logic signed [31:0] lpos  = '0;
   logic               limit_pos, limit_neg, index_pulse, motor_stopped, offset_done;
   logic               cmd_run, cmd_dir_neg, home_set, offset_go, homing_done, homing_err;
   logic [12:0]        cmd_speed, offset_speed, exp_slow, first_spd, last_spd, go_spd;
   logic [11:0]        cmd_accel, cmd_decel, acc_seen, first_dec;
   logic [31:0]        offset_dist, go_dist;
   logic [7:0]         err_code;
   logic               run_q, idx_q, first_dir, last_dir, got_first, got_dec;
   int                 idx_cnt, sets, gos;
   int                 mismatches = 0;
   int                 tests_run  = 0;

   always #25 mclk = ~mclk;

   hsq_top #(.LIM_LAT_CYC(4)) dut (
      .mclk(mclk), .rst_b(rst_b), .start(start), .cfg(cfg), .limit_pos(limit_pos),
      .limit_neg(limit_neg), .index_pulse(index_pulse), .motor_stopped(motor_stopped),
      .offset_done(offset_done), .cmd_run(cmd_run), .cmd_dir_neg(cmd_dir_neg),
      .cmd_speed(cmd_speed), .cmd_accel(cmd_accel), .cmd_decel(cmd_decel),
      .home_set(home_set), .offset_go(offset_go), .offset_dist(offset_dist),
      .offset_speed(offset_speed), .homing_done(homing_done), .homing_err(homing_err),
      .err_code(err_code)
   );

   hsq_motor_model mdl (
      .mclk(mclk), .load(load), .load_pos(lpos), .stuck_pos(stuck), .cmd_run(cmd_run),
      .cmd_dir_neg(cmd_dir_neg), .cmd_decel(cmd_decel), .offset_go(offset_go),
      .limit_pos(limit_pos), .limit_neg(limit_neg), .index_pulse(index_pulse),
      .motor_stopped(motor_stopped), .offset_done(offset_done)
   );

   // Record first and last move phase, first stop ramp, index edges while creeping
   always @(posedge mclk) begin
      run_q <= cmd_run;
      idx_q <= index_pulse;
      if (cmd_run === 1'b1 && !got_first) begin
         first_dir <= cmd_dir_neg;
         first_spd <= cmd_speed;
         acc_seen  <= cmd_accel;
         got_first <= 1'b1;
      end
      if (cmd_run === 1'b1) begin
         last_dir <= cmd_dir_neg;
         last_spd <= cmd_speed;
      end
      if (cmd_run === 1'b0 && run_q === 1'b1 && !got_dec) begin
         first_dec <= cmd_decel;
         got_dec   <= 1'b1;
      end
      if (cmd_run === 1'b1 && index_pulse && !idx_q && cmd_speed === exp_slow) idx_cnt <= idx_cnt + 1;
      if (home_set === 1'b1) sets <= sets + 1;
      if (offset_go === 1'b1) begin
         gos     <= gos + 1;
         go_dist <= offset_dist;
         go_spd  <= offset_speed;
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task finish_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // Fresh reset each run so done and error flags never carry over
   task run(input int p, input logic stk);
      @(negedge mclk) rst_b = 1'b0;
      lpos  = p;
      stuck = stk;
      load  = 1'b1;
      repeat (8) @(negedge mclk);
      rst_b     = 1'b1;
      load      = 1'b0;
      exp_slow  = (cfg.slow_speed > hsq_pkg::SPEED_MAX) ? hsq_pkg::SPEED_MAX : cfg.slow_speed;
      got_first = 1'b0;
      got_dec   = 1'b0;
      idx_cnt   = 0;
      sets      = 0;
      gos       = 0;
      start     = 1'b1;
      @(negedge mclk) start = 1'b0;
      for (int i = 0; i < 4000 && homing_done !== 1'b1 && homing_err !== 1'b1; i++)
         @(negedge mclk);
      repeat (2) @(negedge mclk);
   endtask : run

   // Timeout guard well beyond the longest expected run
   initial begin
      #(50 * 60000);
      mismatches++;
      finish_test();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      // Index-only, positive, third pulse, unused fast speed of zero tolerated
      cfg = '{13'h000, 13'h064, 13'h0C8, 12'h1F4, 12'h190, 1'b0, 4'h5, 1'b0, 8'h03, 32'h0, 2'h0};
      run(10, 1'b0);
      check(homing_done, 1'b1);
      check(homing_err, 1'b0);
      check(idx_cnt, 3);
      check(sets, 1);
      check(gos, 0);
      check(first_spd, 13'h064);
      check(first_dir, 1'b0);
      // Index-only, negative, first pulse, offset move with clamped speed
      cfg = '{13'h3E8, 13'h064, 13'h1B58, 12'h1F4, 12'h190, 1'b1, 4'h5, 1'b1, 8'h01,
              -32'sd25, 2'h0};
      run(-10, 1'b0);
      check(first_dir, 1'b1);
      check(idx_cnt, 1);
      check(gos, 1);
      check(go_dist, 32'hFFFFFFE7);
      check(go_spd, hsq_pkg::SPEED_MAX);
      check(homing_done, 1'b1);
      // Limit plus index: fast away, instant stop, slow back, two pulses, zero offset
      cfg = '{13'h3E8, 13'h064, 13'h0C8, 12'h1F4, 12'h190, 1'b0, 4'h3, 1'b1, 8'h02, 32'h0, 2'h1};
      run(0, 1'b0);
      check(first_dir, 1'b1);
      check(first_spd, 13'h3E8);
      check(first_dec, 12'h000);
      check(last_dir, 1'b0);
      check(last_spd, 13'h064);
      check(idx_cnt, 2);
      check(gos, 0);
      check(homing_done, 1'b1);
      // Limit edge: clamped fast toward limit, ramped stop, slow reverse to release
      cfg = '{13'h1B58, 13'h064, 13'h0C8, 12'hDAC, 12'h190, 1'b0, 4'h4, 1'b0, 8'h01, 32'h0, 2'h2};
      run(100, 1'b0);
      check(first_dir, 1'b0);
      check(first_spd, hsq_pkg::SPEED_MAX);
      check(acc_seen, hsq_pkg::ACCEL_MAX);
      check(first_dec, 12'h190);
      check(last_dir, 1'b1);
      check(sets, 1);
      check(homing_done, 1'b1);
      // Limit edge with a stuck sensor and instant stops: reverse leg meets the far limit
      cfg.ot_action = 2'h3;
      run(100, 1'b1);
      check(first_dec, 12'h000);
      check(cmd_decel, 12'h000);
      check(homing_err, 1'b1);
      check(err_code, hsq_pkg::ERR_HOMING);
      check(sets, 0);
      // Index-only reaching the travel limit before the count: trip, start refused
      cfg = '{13'h3E8, 13'h064, 13'h0C8, 12'h1F4, 12'h190, 1'b0, 4'h5, 1'b0, 8'h14, 32'h0, 2'h0};
      run(10, 1'b0);
      check(homing_err, 1'b1);
      check(err_code, hsq_pkg::ERR_HOMING);
      check(homing_done, 1'b0);
      start = 1'b1;
      @(negedge mclk) start = 1'b0;
      repeat (3) @(negedge mclk);
      check(cmd_run, 1'b0);
      check(homing_err, 1'b1);
      // Each required zero setting and an unknown type trip at once
      for (int k = 0; k < 5; k++) begin
         cfg = '{13'h3E8, 13'h064, 13'h0C8, 12'h1F4, 12'h190, 1'b0, 4'h3, 1'b0, 8'h01, 32'h0, 2'h0};
         if (k == 0) cfg.fast_speed = 13'h000;
         if (k == 1) cfg.slow_speed = 13'h000;
         if (k == 2) cfg.accel = 12'h000;
         if (k == 3) cfg.decel = 12'h000;
         if (k == 4) cfg.homing_type = 4'h6;
         run(0, 1'b0);
         check(err_code, hsq_pkg::ERR_HOMING);
         check(cmd_run, 1'b0);
         check(got_first, 1'b0);
      end
      finish_test();
   end
endmodule : test_homing_sequencer_limit_zphase
